// ===== verilog/lpm_pkg.sv
package lpm_pkg;

    // Register byte addresses
    localparam logic [7:0] POWER_CONTROL_ADDR        = 8'h00;
    localparam logic [7:0] POWER_STATUS_ADDR         = 8'h04;
    localparam logic [7:0] BACKUP_CONTROL_ADDR       = 8'h08;
    localparam logic [7:0] WATCHDOG_ENABLE_ADDR      = 8'h0C;
    localparam logic [7:0] MODE_STATUS_ADDR          = 8'h10;

    // Power control fields
    localparam int PCR_POWER_DOWN_BIT       = 0;
    localparam int PCR_CLEAR_WAKEUP_BIT     = 2;
    localparam int PCR_CLEAR_STANDBY_BIT    = 3;

    // Power control/status fields
    localparam int PCSR_WAKEUP_FLAG_BIT     = 0;
    localparam int PCSR_STANDBY_FLAG_BIT    = 1;
    localparam int PCSR_WAKEUP_PIN_EN_BIT   = 8;

    // Backup domain control fields
    localparam int BDCR_SLOW_CRYSTAL_BIT    = 0;
    localparam int BDCR_CAL_OUT_BIT         = 2;
    localparam int BDCR_RTC_SEL_LSB         = 8;
    localparam int BDCR_RTC_ENABLE_BIT      = 15;

    // Watchdog enable key bit
    localparam int WDG_START_BIT            = 0;

    // Clock selections for the rtc
    localparam logic [1:0] RTC_SEL_NONE     = 2'h0;
    localparam logic [1:0] RTC_SEL_CRYSTAL  = 2'h1;
    localparam logic [1:0] RTC_SEL_INTERNAL = 2'h2;

    // Reset values
    localparam logic [1:0] RTC_SEL_RESET    = 2'h0;
    localparam int RESET_PHASE_CYCLES       = 16;

    // Operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_RUN       = 6'h01,
        MODE_SLEEP     = 6'h02,
        MODE_STOP_WAIT = 6'h04,
        MODE_STOP      = 6'h08,
        MODE_STANDBY   = 6'h10,
        MODE_WAKE_RST  = 6'h20
    } lpm_mode_t;

    // Wait request from the core
    typedef struct packed {
        logic valid;
        logic is_event;
        logic deep_sleep_select;
    } wait_req_t;

    // Pending conditions sampled at entry
    typedef struct packed {
        logic ext_line;
        logic peripheral;
        logic rtc_alarm_flag;
    } pending_t;

endpackage

// ===== verilog/low_power_mode_controller.sv
// Overview of operation
// - Stop halts core clocks, PLL and both fast oscillators; state retained.
// - In Stop every pad holds its Run level and configuration.
// - Stop entry waits while flash programming is busy.
// - Stop entry waits while a peripheral bus transfer is outstanding.
// - Watchdog once started runs through Stop and Standby until reset.
// - Rtc and slow crystal follow their backup enable bits in low power.
// - Leaving Stop selects the internal fast oscillator as system clock.
// - Stop needs a wait with deep sleep set and power down clear.
// - Any pending line, interrupt or alarm flag cancels the Stop request.
// - Stop exit by interrupt lines after wfi, event lines after wfe.
// - Standby turns off regulator, core supply, PLL and fast oscillators.
// - Standby needs deep sleep, power down, clear wakeup flag, no pending.
// - Standby ends on reset pin, watchdog, wakeup pin edge or alarm rise.
// - Standby wakeup resets registers and restarts like a reset.
// - Standby flag set and kept across the wakeup reset.
// - Standby pads float except reset, calibration output, wakeup pin.
// - Two-bit field picks slow crystal or internal slow oscillator for rtc.
// - Wait with deep sleep clear stops only the cpu clock.
// - Standby exit issues a power reset, not a backup reset.
`timescale 1ns/1ps
module low_power_mode_controller
    import lpm_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_PHASE_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Core wait request
    input  wire wait_req_t   wait_req,
    output logic             core_wake,
    // Entry conditions
    input  wire pending_t    pending,
    input  wire logic        flash_busy,
    input  wire logic        apb_busy,
    // Wakeup sources and watchdog hardware start
    input  wire logic        line_irq_wake,
    input  wire logic        line_event_wake,
    input  wire logic        wakeup_pin,
    input  wire logic        rtc_alarm,
    input  wire logic        reset_pin_n,
    input  wire logic        watchdog_reset,
    input  wire logic        watchdog_hw_start,
    // Clock and supply control
    output logic             cpu_clock_en,
    output logic             core_clock_en,
    output logic             pll_en,
    output logic             internal_fast_osc_en,
    output logic             external_fast_osc_en,
    output logic             select_internal_fast_osc,
    output logic             regulator_en,
    output logic             power_reset,
    // Backup domain control
    output logic             rtc_run,
    output logic             slow_crystal_run,
    output logic       [1:0] rtc_clock_select,
    output logic             watchdog_run,
    // Pad control and mode
    output logic             pad_hold,
    output logic             pad_float,
    output logic             rtc_cal_pin_keep,
    output logic             wakeup_pin_keep,
    output lpm_mode_t        mode
);

    localparam logic [7:0] RESET_LAST = 8'(RESET_CYCLES - 1);

    lpm_mode_t  state_q, state_d;
    logic       wfe_q;
    logic       power_down_select_q;
    logic       wakeup_flag_q;
    logic       standby_flag_q;
    logic       wakeup_pin_en_q;
    logic       low_speed_crystal_on_q;
    logic       rtc_enable_bit_q;
    logic       cal_out_en_q;
    logic [1:0] rtc_sel_q;
    logic       watchdog_run_q;
    logic       wakeup_pin_prev_q;
    logic       rtc_alarm_prev_q;
    logic [7:0] reset_count_q;
    logic       any_pending;
    logic       pin_edge;
    logic       alarm_rise;
    logic       standby_exit;
    logic       stop_exit;
    logic       sleep_exit;
    logic       soft_reset;

    assign any_pending = pending.ext_line | pending.peripheral |
                         pending.rtc_alarm_flag;
    assign pin_edge    = wakeup_pin_en_q & (wakeup_pin ^ wakeup_pin_prev_q);
    assign alarm_rise  = rtc_alarm & ~rtc_alarm_prev_q;
    assign standby_exit = ~reset_pin_n | watchdog_reset | pin_edge |
                          alarm_rise;
    assign stop_exit   = wfe_q ? line_event_wake : line_irq_wake;
    assign sleep_exit  = stop_exit | pending.peripheral;
    assign soft_reset  = rst | (state_q == MODE_WAKE_RST);

    // Mode sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            MODE_RUN: begin
                if (wait_req.valid) begin
                    if (!wait_req.deep_sleep_select) begin
                        state_d = MODE_SLEEP;
                    end else if (!power_down_select_q) begin
                        if (!any_pending) begin
                            state_d = MODE_STOP_WAIT;
                        end
                    end else if (!any_pending && !wakeup_flag_q) begin
                        state_d = MODE_STANDBY;
                    end
                end
            end
            MODE_SLEEP: begin
                if (sleep_exit) begin
                    state_d = MODE_RUN;
                end
            end
            MODE_STOP_WAIT: begin
                if (!flash_busy && !apb_busy) begin
                    state_d = MODE_STOP;
                end
            end
            MODE_STOP: begin
                if (stop_exit) begin
                    state_d = MODE_RUN;
                end
            end
            MODE_STANDBY: begin
                if (standby_exit) begin
                    state_d = MODE_WAKE_RST;
                end
            end
            MODE_WAKE_RST: begin
                if (reset_count_q == RESET_LAST) begin
                    state_d = MODE_RUN;
                end
            end
            default: begin
                state_d = MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= MODE_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Entry instruction kind
    always_ff @(posedge clock) begin
        if (rst) begin
            wfe_q <= 1'b0;
        end else if (state_q == MODE_RUN && wait_req.valid) begin
            wfe_q <= wait_req.is_event;
        end
    end

    // Reset phase counter
    always_ff @(posedge clock) begin
        if (rst || state_q != MODE_WAKE_RST) begin
            reset_count_q <= 8'h00;
        end else begin
            reset_count_q <= reset_count_q + 8'h01;
        end
    end

    // Edge history of wakeup inputs
    always_ff @(posedge clock) begin
        if (rst) begin
            wakeup_pin_prev_q <= 1'b0;
            rtc_alarm_prev_q  <= 1'b0;
        end else begin
            wakeup_pin_prev_q <= wakeup_pin;
            rtc_alarm_prev_q  <= rtc_alarm;
        end
    end

    // Power control register and wakeup pin enable, lost in the wakeup reset
    always_ff @(posedge clock) begin
        if (soft_reset) begin
            power_down_select_q <= 1'b0;
            wakeup_pin_en_q     <= 1'b0;
        end else if (reg_write && reg_addr == POWER_CONTROL_ADDR) begin
            power_down_select_q <= reg_wdata[PCR_POWER_DOWN_BIT];
        end else if (reg_write && reg_addr == POWER_STATUS_ADDR) begin
            wakeup_pin_en_q <= reg_wdata[PCSR_WAKEUP_PIN_EN_BIT];
        end
    end

    // Wakeup flag, set wins over clear
    always_ff @(posedge clock) begin
        if (rst) begin
            wakeup_flag_q <= 1'b0;
        end else if (pin_edge || alarm_rise) begin
            wakeup_flag_q <= 1'b1;
        end else if (reg_write && reg_addr == POWER_CONTROL_ADDR &&
                     reg_wdata[PCR_CLEAR_WAKEUP_BIT]) begin
            wakeup_flag_q <= 1'b0;
        end
    end

    // Standby flag, survives the wakeup reset
    always_ff @(posedge clock) begin
        if (rst) begin
            standby_flag_q <= 1'b0;
        end else if (state_q == MODE_STANDBY) begin
            standby_flag_q <= 1'b1;
        end else if (reg_write && reg_addr == POWER_CONTROL_ADDR &&
                     reg_wdata[PCR_CLEAR_STANDBY_BIT]) begin
            standby_flag_q <= 1'b0;
        end
    end

    // Backup domain control
    always_ff @(posedge clock) begin
        if (rst) begin
            low_speed_crystal_on_q <= 1'b0;
            rtc_enable_bit_q       <= 1'b0;
            cal_out_en_q           <= 1'b0;
            rtc_sel_q              <= RTC_SEL_RESET;
        end else if (reg_write && reg_addr == BACKUP_CONTROL_ADDR) begin
            low_speed_crystal_on_q <= reg_wdata[BDCR_SLOW_CRYSTAL_BIT];
            rtc_enable_bit_q       <= reg_wdata[BDCR_RTC_ENABLE_BIT];
            cal_out_en_q           <= reg_wdata[BDCR_CAL_OUT_BIT];
            rtc_sel_q              <=
                reg_wdata[BDCR_RTC_SEL_LSB +: 2];
        end
    end

    // Watchdog start, cleared only by reset
    always_ff @(posedge clock) begin
        if (rst) begin
            watchdog_run_q <= 1'b0;
        end else if (watchdog_hw_start ||
                     (reg_write && reg_addr == WATCHDOG_ENABLE_ADDR &&
                      reg_wdata[WDG_START_BIT])) begin
            watchdog_run_q <= 1'b1;
        end
    end

    // Read data
    always_ff @(posedge clock) begin
        if (rst || !reg_read) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
            case (reg_addr)
                POWER_CONTROL_ADDR: begin
                    reg_rdata[PCR_POWER_DOWN_BIT] <= power_down_select_q;
                end
                POWER_STATUS_ADDR: begin
                    reg_rdata[PCSR_WAKEUP_FLAG_BIT]   <= wakeup_flag_q;
                    reg_rdata[PCSR_STANDBY_FLAG_BIT]  <= standby_flag_q;
                    reg_rdata[PCSR_WAKEUP_PIN_EN_BIT] <= wakeup_pin_en_q;
                end
                BACKUP_CONTROL_ADDR: begin
                    reg_rdata[BDCR_SLOW_CRYSTAL_BIT] <= low_speed_crystal_on_q;
                    reg_rdata[BDCR_CAL_OUT_BIT]      <= cal_out_en_q;
                    reg_rdata[BDCR_RTC_SEL_LSB +: 2] <= rtc_sel_q;
                    reg_rdata[BDCR_RTC_ENABLE_BIT]   <= rtc_enable_bit_q;
                end
                WATCHDOG_ENABLE_ADDR: begin
                    reg_rdata[WDG_START_BIT] <= watchdog_run_q;
                end
                MODE_STATUS_ADDR: begin
                    reg_rdata[5:0] <= state_q;
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Clock and supply outputs follow the next mode
    always_ff @(posedge clock) begin
        if (rst) begin
            cpu_clock_en         <= 1'b1;
            core_clock_en        <= 1'b1;
            pll_en               <= 1'b1;
            internal_fast_osc_en <= 1'b1;
            external_fast_osc_en <= 1'b1;
            regulator_en         <= 1'b1;
        end else begin
            cpu_clock_en  <= (state_d == MODE_RUN);
            core_clock_en <= state_d inside {MODE_RUN, MODE_SLEEP,
                                             MODE_STOP_WAIT};
            pll_en        <= !(state_d inside {MODE_STOP, MODE_STANDBY,
                                               MODE_WAKE_RST});
            internal_fast_osc_en <= !(state_d inside {MODE_STOP,
                                                      MODE_STANDBY});
            external_fast_osc_en <= !(state_d inside {MODE_STOP,
                                                      MODE_STANDBY,
                                                      MODE_WAKE_RST});
            regulator_en  <= (state_d != MODE_STANDBY);
        end
    end

    // Exit pulses
    always_ff @(posedge clock) begin
        if (rst) begin
            select_internal_fast_osc <= 1'b0;
            core_wake                <= 1'b0;
            power_reset              <= 1'b0;
        end else begin
            select_internal_fast_osc <= (state_q == MODE_STOP) &&
                                        stop_exit;
            core_wake   <= (state_q == MODE_STOP || state_q == MODE_SLEEP) &&
                           (state_d == MODE_RUN);
            power_reset <= (state_d == MODE_WAKE_RST);
        end
    end

    // Backup domain and pad outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            rtc_run          <= 1'b0;
            slow_crystal_run <= 1'b0;
            rtc_clock_select <= RTC_SEL_RESET;
            watchdog_run     <= 1'b0;
            pad_hold         <= 1'b0;
            pad_float        <= 1'b0;
            rtc_cal_pin_keep <= 1'b0;
            wakeup_pin_keep  <= 1'b0;
            mode             <= MODE_RUN;
        end else begin
            rtc_run          <= rtc_enable_bit_q;
            slow_crystal_run <= low_speed_crystal_on_q;
            rtc_clock_select <= rtc_sel_q;
            watchdog_run     <= watchdog_run_q;
            pad_hold         <= state_d inside {MODE_STOP};
            pad_float        <= (state_d == MODE_STANDBY);
            rtc_cal_pin_keep <= (state_d == MODE_STANDBY) && cal_out_en_q;
            wakeup_pin_keep  <= (state_d == MODE_STANDBY) && wakeup_pin_en_q;
            mode             <= state_d;
        end
    end

    // Checks
    sequence s_stop_request;
        state_q == MODE_RUN && wait_req.valid && wait_req.deep_sleep_select
        && !power_down_select_q && !any_pending;
    endsequence

    sequence s_standby_request;
        state_q == MODE_RUN && wait_req.valid && wait_req.deep_sleep_select
        && power_down_select_q && !any_pending && !wakeup_flag_q;
    endsequence

    a_stop_entry_taken: assert property (
        @(posedge clock) disable iff (rst)
        s_stop_request |=> state_q == MODE_STOP_WAIT)
        else $error("stop request not taken");

    a_pending_cancels: assert property (
        @(posedge clock) disable iff (rst)
        state_q == MODE_RUN && wait_req.valid && wait_req.deep_sleep_select
        && any_pending |=> state_q == MODE_RUN)
        else $error("pending condition did not cancel entry");

    a_busy_delays_stop: assert property (
        @(posedge clock) disable iff (rst)
        state_q == MODE_STOP_WAIT && (flash_busy || apb_busy)
        |=> state_q == MODE_STOP_WAIT)
        else $error("stop entered while busy");

    a_stop_clocks_off: assert property (
        @(posedge clock) disable iff (rst)
        state_q == MODE_STOP_WAIT && !flash_busy && !apb_busy
        |=> !core_clock_en && !pll_en && !internal_fast_osc_en
            && !external_fast_osc_en && pad_hold && regulator_en)
        else $error("stop clocks not halted");

    a_stop_exit_osc: assert property (
        @(posedge clock) disable iff (rst)
        state_q == MODE_STOP && stop_exit
        |=> select_internal_fast_osc && core_wake && state_q == MODE_RUN)
        else $error("stop exit not handled");

    a_standby_power: assert property (
        @(posedge clock) disable iff (rst)
        s_standby_request |=> !regulator_en && pad_float
        ##1 standby_flag_q)
        else $error("standby entry wrong");

    a_standby_wake_reset: assert property (
        @(posedge clock) disable iff (rst)
        state_q == MODE_STANDBY && standby_exit
        |=> power_reset [*2] ##0 state_q == MODE_WAKE_RST)
        else $error("standby exit without power reset");

    a_reset_phase_len: assert property (
        @(posedge clock) disable iff (rst)
        $rose(state_q == MODE_WAKE_RST)
        |-> ##[1:300] state_q == MODE_RUN && !power_down_select_q
            && standby_flag_q)
        else $error("reset phase did not restart with flag kept");

    a_sleep_cpu_only: assert property (
        @(posedge clock) disable iff (rst)
        state_q == MODE_RUN && wait_req.valid && !wait_req.deep_sleep_select
        |=> !cpu_clock_en && core_clock_en && pll_en)
        else $error("sleep gated more than the cpu clock");

    a_watchdog_sticky: assert property (
        @(posedge clock) disable iff (rst)
        watchdog_run_q |=> watchdog_run_q ##0 watchdog_run)
        else $error("watchdog stopped without reset");

endmodule

// ===== bench/core_model.sv
`timescale 1ns/1ps
// Core side: turns a bench command into one wfi or wfe request
module core_model
    import lpm_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Bench command
    input  wire logic issue,
    input  wire logic use_event,
    input  wire logic deep,
    // Request to the controller
    output wait_req_t wait_req
);
    // One-cycle pulse, kind and deep sleep held behind it
    always_ff @(posedge clock) begin
        if (rst) begin
            wait_req <= '0;
        end else begin
            wait_req.valid             <= issue;
            wait_req.is_event          <= use_event;
            wait_req.deep_sleep_select <= deep;
        end
    end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb
    import lpm_pkg::*;
;
    localparam int RST_N = 4;
    logic clock, rst, reg_write, reg_read, core_wake, flash_busy, apb_busy;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    wait_req_t wait_req;
    pending_t pending;
    logic line_irq_wake, line_event_wake, wakeup_pin, rtc_alarm;
    logic reset_pin_n, watchdog_reset, watchdog_hw_start, issue, use_event;
    logic deep, cpu_clock_en, core_clock_en, pll_en, internal_fast_osc_en;
    logic external_fast_osc_en, select_internal_fast_osc, regulator_en;
    logic power_reset, rtc_run, slow_crystal_run, watchdog_run, pad_hold;
    logic pad_float, rtc_cal_pin_keep, wakeup_pin_keep;
    logic [1:0] rtc_clock_select;
    lpm_mode_t mode;
    int miscompares = 0;
    int comparisons = 0;

    core_model core (.clock, .rst, .issue, .use_event, .deep, .wait_req);

    low_power_mode_controller #(.RESET_CYCLES(RST_N)) uut (
        .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .wait_req, .core_wake, .pending, .flash_busy,
        .apb_busy, .line_irq_wake, .line_event_wake, .wakeup_pin,
        .rtc_alarm, .reset_pin_n, .watchdog_reset, .watchdog_hw_start,
        .cpu_clock_en, .core_clock_en, .pll_en, .internal_fast_osc_en,
        .external_fast_osc_en, .select_internal_fast_osc, .regulator_en,
        .power_reset, .rtc_run, .slow_crystal_run, .rtc_clock_select,
        .watchdog_run, .pad_hold, .pad_float, .rtc_cal_pin_keep,
        .wakeup_pin_keep, .mode);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mode(input lpm_mode_t exp);
        chk("mode", 32'(exp), 32'(mode));
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk("rdata", exp, reg_rdata);
    endtask

    task automatic req(input logic ev, input logic dp);
        @(posedge clock);
        issue     <= 1'b1;
        use_event <= ev;
        deep      <= dp;
        @(posedge clock);
        issue <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic phase();
        int n;
        n = 0;
        while (power_reset === 1'b1 && n < 64) begin
            n++;
            @(posedge clock);
            #1;
        end
        chk("reset_len", RST_N, n);
        chk_mode(MODE_RUN);
    endtask

    task automatic t_reset();
        #1 chk_mode(MODE_RUN);
        chk("enables", 6'h3F, {cpu_clock_en, core_clock_en, pll_en,
            internal_fast_osc_en, external_fast_osc_en,
            regulator_en});
        chk("rtc_sel", RTC_SEL_RESET, rtc_clock_select);
        rd(POWER_STATUS_ADDR, 32'h0);
        rd(MODE_STATUS_ADDR, 32'h1);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
    endtask

    task automatic t_sleep();
        req(1'b0, 1'b0);
        chk_mode(MODE_SLEEP);
        chk("clk_en", 2'b01, {cpu_clock_en, core_clock_en});
        @(posedge clock);
        line_irq_wake <= 1'b1;
        @(posedge clock);
        #1 chk_mode(MODE_RUN);
        chk("core_wake", 1'b1, core_wake);
        @(posedge clock);
        line_irq_wake <= 1'b0;
    endtask

    task automatic t_stop();
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            pending <= pending_t'(3'h1 << i);
            req(1'b0, 1'b1);
            chk_mode(MODE_RUN);
        end
        @(posedge clock);
        pending    <= '0;
        flash_busy <= 1'b1;
        req(1'b1, 1'b1);
        chk_mode(MODE_STOP_WAIT);
        @(posedge clock);
        flash_busy <= 1'b0;
        apb_busy   <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk_mode(MODE_STOP_WAIT);
        @(posedge clock);
        apb_busy <= 1'b0;
        @(posedge clock);
        #1 chk_mode(MODE_STOP);
        chk("clocks", 5'h00, {cpu_clock_en, core_clock_en, pll_en,
            internal_fast_osc_en, external_fast_osc_en});
        chk("pad_hold", 1'b1, pad_hold);
        @(posedge clock);
        line_irq_wake <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk_mode(MODE_STOP);
        @(posedge clock);
        line_irq_wake   <= 1'b0;
        line_event_wake <= 1'b1;
        @(posedge clock);
        #1 chk_mode(MODE_RUN);
        chk("exit", 3'h7,
            {core_wake, select_internal_fast_osc, pll_en});
        @(posedge clock);
        line_event_wake <= 1'b0;
    endtask

    task automatic t_standby();
        wr(BACKUP_CONTROL_ADDR, 32'h0000_8105);
        repeat (2) @(posedge clock);
        #1 chk("bk", 4'hD,
               {rtc_run, slow_crystal_run, rtc_clock_select});
        wr(BACKUP_CONTROL_ADDR, 32'h0000_8205);
        repeat (2) @(posedge clock);
        #1 chk("rtc_sel", RTC_SEL_INTERNAL, rtc_clock_select);
        wr(WATCHDOG_ENABLE_ADDR, 32'h1);
        wr(POWER_STATUS_ADDR, 32'h100);
        wr(POWER_CONTROL_ADDR, 32'h1);
        req(1'b0, 1'b1);
        chk_mode(MODE_STANDBY);
        chk("off", 5'h01, {regulator_en, pll_en, internal_fast_osc_en,
            external_fast_osc_en, pad_float});
        chk("keep", 2'b11, {rtc_cal_pin_keep, wakeup_pin_keep});
        @(posedge clock);
        rtc_alarm <= 1'b1;
        @(posedge clock);
        #1 chk_mode(MODE_WAKE_RST);
        phase();
        @(posedge clock);
        rtc_alarm <= 1'b0;
        rd(POWER_STATUS_ADDR, 32'h3);
        rd(POWER_CONTROL_ADDR, 32'h0);
        chk("wdg_rtc", 2'b11, {watchdog_run, rtc_run});
        wr(POWER_CONTROL_ADDR, 32'h1);
        req(1'b0, 1'b1);
        chk_mode(MODE_RUN);
        wr(POWER_CONTROL_ADDR, 32'h5);
        rd(POWER_STATUS_ADDR, 32'h2);
        req(1'b1, 1'b1);
        chk_mode(MODE_STANDBY);
        chk("wakeup_pin_keep", 1'b0, wakeup_pin_keep);
        @(posedge clock);
        watchdog_reset <= 1'b1;
        @(posedge clock);
        watchdog_reset <= 1'b0;
        #1 chk_mode(MODE_WAKE_RST);
        phase();
        chk("wdg", 1'b1, watchdog_run);
        wr(POWER_CONTROL_ADDR, 32'h8);
        rd(POWER_STATUS_ADDR, 32'h0);
    endtask

    task automatic t_rerun();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1 chk("after_rst", 3'h0, {watchdog_run, rtc_run, pad_float});
        chk_mode(MODE_RUN);
        @(posedge clock);
        watchdog_hw_start <= 1'b1;
        @(posedge clock);
        watchdog_hw_start <= 1'b0;
        @(posedge clock);
        #1 chk("wdg_hw", 1'b1, watchdog_run);
        wr(POWER_STATUS_ADDR, 32'h100);
        wr(POWER_CONTROL_ADDR, 32'h1);
        req(1'b0, 1'b1);
        chk_mode(MODE_STANDBY);
        chk("wakeup_pin_keep", 1'b1, wakeup_pin_keep);
        @(posedge clock);
        wakeup_pin <= 1'b1;
        @(posedge clock);
        #1 chk_mode(MODE_WAKE_RST);
        phase();
        rd(POWER_STATUS_ADDR, 32'h3);
        wr(POWER_CONTROL_ADDR, 32'h5);
        req(1'b0, 1'b1);
        chk_mode(MODE_STANDBY);
        @(posedge clock);
        reset_pin_n <= 1'b0;
        @(posedge clock);
        reset_pin_n <= 1'b1;
        #1 chk_mode(MODE_WAKE_RST);
        phase();
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clock);
        miscompares++;
        print_verdict();
    end

    initial begin
        {rst, reg_write, reg_read, issue, use_event, deep} = 6'h21;
        {flash_busy, apb_busy, line_irq_wake, line_event_wake} = 4'h0;
        {wakeup_pin, rtc_alarm, watchdog_reset, watchdog_hw_start} = 4'h0;
        reg_addr    = 8'h00;
        reg_wdata   = 32'h0;
        pending     = '0;
        reset_pin_n = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_sleep();
        t_stop();
        t_standby();
        t_rerun();
        print_verdict();
    end
endmodule
